// file: core/tidc_pkg.sv
// Package: register map, field positions and codes of the timer interrupt/DMA control block
package tidc_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] TIDC_OFS_CNT_PTR = 8'hf0;   // DMA counter pointer
    localparam logic [7:0] TIDC_OFS_ADR_PTR = 8'hf1;   // DMA address pointer
    localparam logic [7:0] TIDC_OFS_VECTOR = 8'hf2;    // Vector base
    localparam logic [7:0] TIDC_OFS_CONTROL = 8'hf3;   // Control
    localparam logic [7:0] TIDC_OFS_MASK = 8'hff;      // Mask
    // ==========================================
    // Reset values
    localparam logic [7:0] TIDC_RST_CONTROL = 8'hc7;
    localparam logic [7:0] TIDC_RST_MASK = 8'h00;
    localparam logic [7:0] TIDC_RST_ZERO = 8'h00;      // Undefined-reset registers start here
    // ==========================================
    // Mask register fields
    localparam int TIDC_M_GLOBAL = 7;
    localparam int TIDC_M_CP0_DMA = 6;
    localparam int TIDC_M_CP0_IRQ = 5;
    localparam int TIDC_M_CP1_IRQ = 4;
    localparam int TIDC_M_CM0_DMA = 3;
    localparam int TIDC_M_CM0_IRQ = 2;
    localparam int TIDC_M_CM1_IRQ = 1;
    localparam int TIDC_M_WRAP_IRQ = 0;
    // ==========================================
    // Control register fields
    localparam int TIDC_C_CP0_EOB = 7;
    localparam int TIDC_C_CM0_EOB = 6;
    localparam int TIDC_C_SRC_SEL = 5;
    localparam int TIDC_C_DST_SEL = 4;
    localparam int TIDC_C_SWAP = 3;
    localparam int TIDC_C_PRIO_HI = 2;
    // ==========================================
    // Pointer fields
    localparam int TIDC_P_HIGH_LO = 2;                 // Lowest of the six high bits
    localparam int TIDC_P_CHAN = 1;
    localparam int TIDC_P_SEL = 0;
    // ==========================================
    // Flag register fields (from the timer)
    localparam int TIDC_F_CP0 = 7;
    localparam int TIDC_F_CP1 = 6;
    localparam int TIDC_F_CM0 = 5;
    localparam int TIDC_F_CM1 = 4;
    localparam int TIDC_F_WRAP = 3;
    localparam int TIDC_F_AND = 0;
    // ==========================================
    // Vector group codes
    localparam logic [1:0] TIDC_GRP_WRAP = 2'h0;
    localparam logic [1:0] TIDC_GRP_CAPT = 2'h2;
    localparam logic [1:0] TIDC_GRP_COMP = 2'h3;
    // Request group
    typedef enum logic [1:0] {TIDC_REQ_NONE, TIDC_REQ_WRAP, TIDC_REQ_CAPT, TIDC_REQ_COMP} tidc_req_t;
endpackage : tidc_pkg

// file: core/tidc_core.sv
// Interrupt and DMA control section of a 16-bit multifunction timer
`timescale 1ns/1ps
// ==========================================
// Notes on behaviour
// RULE1: Global enable off suppresses all interrupts
// RULE2: Capture-0 DMA arm cleared at block end
// RULE3: Capture-0 mask enables capture or end-of-block
// RULE4: Capture-1 and compare-1 masks gate their interrupts
// RULE5: Compare-0 DMA arm cleared at block end
// RULE6: Compare-0 mask enables match or end-of-block
// RULE7: Wrap mask gates overflow/underflow interrupt
// RULE8: Counter pointer high bits; swap toggles lowest
// RULE9: Hardware drives channel select, compare is one
// RULE10: Area select: memory zero, register file one
// RULE11: Memory select picks segment register for memory
// RULE12: Address pointer high bits; swap toggles lowest
// RULE13: Register-file DMA ignores address pointer, swap table
// RULE14: Vector register holds five programmable top bits
// RULE15: Vector group code set by raising group
// RULE16: Vector lowest bit always reads zero
// RULE17: Capture-0 end flag: set by swap, else one
// RULE18: Compare-0 end flag: set by swap, else one
// RULE19: Capture DMA source select: register or port
// RULE20: Compare DMA destination select: register or port
// RULE21: Swap enable covers both DMA channels
// RULE22: Three-bit priority level presented with requests
// RULE23: Request needs global enable, mask and flag
module tidc_core
    import tidc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] timer_flag_reg,
    input wire logic capture0_eob_event,
    input wire logic compare0_eob_event,
    input wire logic dma_active_compare,
    output logic irq_request,
    output logic [7:0] irq_vector,
    output logic [2:0] priority_level,
    output logic capture0_dma_req,
    output logic compare0_dma_req,
    output logic dma_use_regfile,
    output logic dma_use_dma_segment,
    output logic [7:0] dma_counter_addr,
    output logic [7:0] dma_address_addr,
    output logic capture_dma_source_sel,
    output logic compare_dma_dest_sel
);
    // ==========================================
    // Register storage
    logic [7:0] mask_reg;           // Mask register
    logic [7:0] control_reg;        // Control register

    logic [7:2] counter_ptr_high;   // Counter pointer top bits
    logic counter_sel_reg;          // Area select
    logic [7:2] address_ptr_high;   // Address pointer top bits

    logic segment_sel_reg;          // Memory segment select

    logic [7:3] vector_high_reg;    // Vector top bits

    logic [1:0] group_reg;          // Last raised group
    logic chan_reg;                 // Channel select, hardware owned

    tidc_req_t req_next;            // Group wanting service
    logic req_any;
    logic capt_src;

    logic wr_mask;
    logic wr_ctrl;

    // ==========================================
    // Usage notes
    // Strobes last one cycle
    // Reads never wait
    // Read data stands one cycle
    // Unmapped reads give zero
    // Unmapped writes are dropped

    // Mask clears on reset
    // Control resets to c7
    // Pointers reset to zero
    // Vector resets to zero

    // Flags come from the timer
    // Flags share this clock
    // Block ends come from the core
    // Core marks compare service

    // Compare wins over capture
    // Capture wins over wrap
    // Group code latched on request
    // Vector follows a cycle later

    // Arm bits drop at block end
    // Hardware clear beats a write
    // Table flips on compare end
    // Capture end keeps the tables

    // Priority shows a cycle late
    // Selects show a cycle late
    // Swap covers both channels

    // AND capture skips block ends
    // Code 01 never appears

    assign wr_mask = reg_write && (reg_addr == TIDC_OFS_MASK);
    assign wr_ctrl = reg_write && (reg_addr == TIDC_OFS_CONTROL);

    // ==========================================
    // Mask register; hardware clear of arm bits beats a software write in that cycle
    // so a finished block is never re-armed by a stale write image
    // Masks are software bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mask_reg <= TIDC_RST_MASK;
        end else begin
            if (wr_mask) begin
                mask_reg <= reg_wdata;                            // RULE4 RULE7
            end
            if (capture0_eob_event) begin
                mask_reg[TIDC_M_CP0_DMA] <= 1'b0;                 // RULE2
            end
            if (compare0_eob_event) begin
                mask_reg[TIDC_M_CM0_DMA] <= 1'b0;                 // RULE5
            end
        end
    end

    // ==========================================
    // Control register; end flags set by hardware win over software clear
    // Swap off holds both flags
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            control_reg <= TIDC_RST_CONTROL;
        end else begin
            if (wr_ctrl) begin
                control_reg <= reg_wdata;                         // RULE19 RULE20 RULE21 RULE22
            end
            // Pending swap value counts
            if (!(wr_ctrl ? reg_wdata[TIDC_C_SWAP] : control_reg[TIDC_C_SWAP])) begin
                // Swap off: both end flags pinned high
                control_reg[TIDC_C_CP0_EOB] <= 1'b1;              // RULE17
                control_reg[TIDC_C_CM0_EOB] <= 1'b1;              // RULE18
            end else begin
                if (capture0_eob_event) begin
                    control_reg[TIDC_C_CP0_EOB] <= 1'b1;          // RULE17
                end
                if (compare0_eob_event) begin
                    control_reg[TIDC_C_CM0_EOB] <= 1'b1;          // RULE18
                end
            end
        end
    end

    // ==========================================
    // Pointer registers; swap toggles the lowest high bit on compare-0 block end
    // Capture end moves nothing
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            counter_ptr_high <= TIDC_RST_ZERO[7:2];
            counter_sel_reg <= 1'b0;
            address_ptr_high <= TIDC_RST_ZERO[7:2];
            segment_sel_reg <= 1'b0;
        end else begin
            if (reg_write && reg_addr == TIDC_OFS_CNT_PTR) begin
                counter_ptr_high <= reg_wdata[7:2];               // RULE8
                counter_sel_reg <= reg_wdata[TIDC_P_SEL];         // RULE10
            end

            if (reg_write && reg_addr == TIDC_OFS_ADR_PTR) begin
                address_ptr_high <= reg_wdata[7:2];               // RULE12
                segment_sel_reg <= reg_wdata[TIDC_P_SEL];         // RULE11
            end

            if (compare0_eob_event && control_reg[TIDC_C_SWAP]) begin
                // Swap: flip to the other table
                counter_ptr_high[TIDC_P_HIGH_LO] <= ~counter_ptr_high[TIDC_P_HIGH_LO]; // RULE8
                address_ptr_high[TIDC_P_HIGH_LO] <= ~address_ptr_high[TIDC_P_HIGH_LO]; // RULE12
            end
        end
    end

    // Channel select follows the active DMA channel
    // Writes to it are dropped
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chan_reg <= 1'b0;
        end else begin
            chan_reg <= dma_active_compare;                       // RULE9
        end
    end

    // ==========================================
    // Vector top bits
    // Low three bits are hardware
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            vector_high_reg <= TIDC_RST_ZERO[7:3];
        end else if (reg_write && reg_addr == TIDC_OFS_VECTOR) begin
            vector_high_reg <= reg_wdata[7:3];                    // RULE14
        end
    end

    // ==========================================
    // Request decode; compare before capture before wrap (fixed order, my pick)
    // One group shown at a time
    always_comb begin
        req_next = TIDC_REQ_NONE;
        // Capture group: OR or AND of both registers
        capt_src = timer_flag_reg[TIDC_F_AND] ?
            (timer_flag_reg[TIDC_F_CP0] && mask_reg[TIDC_M_CP0_IRQ] &&
             timer_flag_reg[TIDC_F_CP1] && mask_reg[TIDC_M_CP1_IRQ]) :
            ((timer_flag_reg[TIDC_F_CP0] && mask_reg[TIDC_M_CP0_IRQ] &&
              !mask_reg[TIDC_M_CP0_DMA]) ||                       // RULE3
             (timer_flag_reg[TIDC_F_CP1] && mask_reg[TIDC_M_CP1_IRQ]) || // RULE4
             (capture0_eob_event && mask_reg[TIDC_M_CP0_IRQ] && mask_reg[TIDC_M_CP0_DMA]));
        // Compare, capture, wrap
        if (mask_reg[TIDC_M_GLOBAL]) begin                        // RULE1 RULE23
            if ((timer_flag_reg[TIDC_F_CM0] && mask_reg[TIDC_M_CM0_IRQ] &&
                 !mask_reg[TIDC_M_CM0_DMA]) ||                    // RULE6
                (compare0_eob_event && mask_reg[TIDC_M_CM0_IRQ] && mask_reg[TIDC_M_CM0_DMA]) ||
                (timer_flag_reg[TIDC_F_CM1] && mask_reg[TIDC_M_CM1_IRQ])) begin // RULE4
                req_next = TIDC_REQ_COMP;
            end else if (capt_src) begin
                req_next = TIDC_REQ_CAPT;                         // RULE3
            end else if (timer_flag_reg[TIDC_F_WRAP] && mask_reg[TIDC_M_WRAP_IRQ]) begin
                req_next = TIDC_REQ_WRAP;                         // RULE7
            end
        end

        req_any = (req_next != TIDC_REQ_NONE);
    end

    // Latch group code of the request being presented
    // Idle keeps the last code
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            group_reg <= TIDC_GRP_WRAP;
        end else begin
            unique case (req_next)
                TIDC_REQ_WRAP: group_reg <= TIDC_GRP_WRAP;        // RULE15
                TIDC_REQ_CAPT: group_reg <= TIDC_GRP_CAPT;        // RULE15
                TIDC_REQ_COMP: group_reg <= TIDC_GRP_COMP;        // RULE15
                TIDC_REQ_NONE: group_reg <= group_reg;            // Hold last code
            endcase
        end
    end

    // ==========================================
    // Registered outputs
    // All outputs leave flip-flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            // Quiet after reset
            irq_request <= 1'b0;
            priority_level <= TIDC_RST_CONTROL[TIDC_C_PRIO_HI:0];
            capture0_dma_req <= 1'b0;
            compare0_dma_req <= 1'b0;
            dma_use_regfile <= 1'b0;
            dma_use_dma_segment <= 1'b0;
            dma_counter_addr <= TIDC_RST_ZERO;
            dma_address_addr <= TIDC_RST_ZERO;
            capture_dma_source_sel <= 1'b0;
            compare_dma_dest_sel <= 1'b0;
        end else begin
            // Request and level
            irq_request <= req_any;                               // RULE23
            priority_level <= control_reg[TIDC_C_PRIO_HI:0];      // RULE22
            // DMA requests need the arm bit and the event flag
            capture0_dma_req <= mask_reg[TIDC_M_CP0_DMA] && timer_flag_reg[TIDC_F_CP0];
            compare0_dma_req <= mask_reg[TIDC_M_CM0_DMA] && timer_flag_reg[TIDC_F_CM0];

            dma_use_regfile <= counter_sel_reg;                   // RULE10
            // Segment choice only matters for memory
            dma_use_dma_segment <= !counter_sel_reg && segment_sel_reg; // RULE11
            dma_counter_addr <= {counter_ptr_high, chan_reg, counter_sel_reg};
            // Register file mode: only the table bit survives
            dma_address_addr <= counter_sel_reg ?
                {5'h00, address_ptr_high[TIDC_P_HIGH_LO], 2'h0} : // RULE13
                {address_ptr_high, chan_reg, segment_sel_reg};

            capture_dma_source_sel <= control_reg[TIDC_C_SRC_SEL]; // RULE19
            compare_dma_dest_sel <= control_reg[TIDC_C_DST_SEL];  // RULE20
        end
    end

    // Vector output: bit 0 always zero
    // Entries stay 16-bit aligned
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_vector <= TIDC_RST_ZERO;
        end else begin
            irq_vector <= {vector_high_reg, group_reg, 1'b0};     // RULE16
        end
    end

    // ==========================================
    // Read port; unmapped addresses read zero
    // Data stands one cycle only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= TIDC_RST_ZERO;
        end else if (reg_read) begin
            unique case (reg_addr)
                // Mapped registers
                TIDC_OFS_MASK: reg_rdata <= mask_reg;
                TIDC_OFS_CONTROL: reg_rdata <= control_reg;
                TIDC_OFS_CNT_PTR: reg_rdata <= {counter_ptr_high, chan_reg, counter_sel_reg};
                TIDC_OFS_ADR_PTR: reg_rdata <= {address_ptr_high, chan_reg, segment_sel_reg};
                TIDC_OFS_VECTOR: reg_rdata <= {vector_high_reg, group_reg, 1'b0}; // RULE16
                default: reg_rdata <= TIDC_RST_ZERO;
            endcase
        end else begin
            reg_rdata <= TIDC_RST_ZERO;
        end
    end

    // ==========================================
    // Checks
    // All idle while in reset
    sequence s_global_off;
        !mask_reg[TIDC_M_GLOBAL];
    endsequence

    a_global_gate_off: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
        s_global_off |=> !irq_request)
        else $error("interrupt raised with global enable off");

    a_cp0_arm_clear: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
        capture0_eob_event |=> !mask_reg[TIDC_M_CP0_DMA])
        else $error("capture0 arm not cleared");

    a_cm0_arm_clear: assert property (@(posedge clk_sys) disable iff (reset) // RULE5
        compare0_eob_event |=> !mask_reg[TIDC_M_CM0_DMA])
        else $error("compare0 arm not cleared");

    a_wrap_irq_path: assert property (@(posedge clk_sys) disable iff (reset) // RULE7
        (mask_reg[TIDC_M_GLOBAL] && mask_reg[TIDC_M_WRAP_IRQ] && timer_flag_reg[TIDC_F_WRAP])
        |=> irq_request)
        else $error("wrap interrupt missing");

    a_vector_low_zero: assert property (@(posedge clk_sys) disable iff (reset) // RULE16
        !irq_vector[0])
        else $error("vector bit zero set");

    a_eob_forced_one: assert property (@(posedge clk_sys) disable iff (reset) // RULE17
        !control_reg[TIDC_C_SWAP] ##1 !control_reg[TIDC_C_SWAP]
        |-> control_reg[TIDC_C_CP0_EOB] && control_reg[TIDC_C_CM0_EOB])
        else $error("end flags not forced with swap off");

    a_group_compare: assert property (@(posedge clk_sys) disable iff (reset) // RULE15
        req_next == TIDC_REQ_COMP |=> ##1 irq_vector[2:1] == TIDC_GRP_COMP)
        else $error("compare group code wrong");

    a_prio_follows: assert property (@(posedge clk_sys) disable iff (reset) // RULE22
        wr_ctrl |=> ##1 priority_level == $past(reg_wdata[TIDC_C_PRIO_HI:0], 2))
        else $error("priority not presented");

    a_swap_toggle: assert property (@(posedge clk_sys) disable iff (reset) // RULE8
        (compare0_eob_event && control_reg[TIDC_C_SWAP] && !reg_write)
        |=> counter_ptr_high[TIDC_P_HIGH_LO] != $past(counter_ptr_high[TIDC_P_HIGH_LO]))
        else $error("swap toggle missing");
endmodule : tidc_core

// file: verification/tidc_dma_partner.sv
// Partner model: core DMA controller serving the timer's two DMA channels
`timescale 1ns/1ps
module tidc_dma_partner (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] block_len,
    input wire logic capture0_dma_req,
    input wire logic compare0_dma_req,
    output logic capture0_eob_event,
    output logic compare0_eob_event,
    output logic dma_active_compare
);
    // ==========================================
    // Block transfer counter
    logic [3:0] xfer_count_reg; // Units moved in the current block
    // Compare channel marked while it is being served
    assign dma_active_compare = compare0_dma_req;
    // One unit per requested cycle; the last unit ends the block with a pulse
    always_ff @(posedge clk_sys) begin
        capture0_eob_event <= 1'b0;
        compare0_eob_event <= 1'b0;
        if (reset) begin
            xfer_count_reg <= 4'h0;
        end else if (!(capture0_dma_req || compare0_dma_req)) begin
            // Idle: restart so a late request tail never shortens the next block
            xfer_count_reg <= 4'h0;
        end else if (xfer_count_reg == block_len - 4'h1) begin
            xfer_count_reg <= 4'h0;
            capture0_eob_event <= !compare0_dma_req;
            compare0_eob_event <= compare0_dma_req;
        end else begin
            xfer_count_reg <= xfer_count_reg + 4'h1;
        end
    end
endmodule : tidc_dma_partner

// file: verification/tb_top.sv
// Self-checking testbench for the timer interrupt/DMA control block
`timescale 1ns/1ps
module tb_top;
    import tidc_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] timer_flag_reg = 8'h00;
    logic [3:0] block_len = 4'h4; // Short block: prompt partner
    logic [7:0] reg_rdata, irq_vector, dma_counter_addr, dma_address_addr;
    logic [2:0] priority_level;
    logic irq_request, capture0_dma_req, compare0_dma_req, dma_use_regfile;
    logic dma_use_dma_segment, capture_dma_source_sel, compare_dma_dest_sel;
    logic capture0_eob_event, compare0_eob_event, dma_active_compare;
    int n_errors = 0;
    int check_count = 0;
    // Source table: flag bit, mask bit, vector group
    int fb [5] = '{TIDC_F_CP0, TIDC_F_CP1, TIDC_F_CM0, TIDC_F_CM1, TIDC_F_WRAP};
    int mb [5] = '{TIDC_M_CP0_IRQ, TIDC_M_CP1_IRQ, TIDC_M_CM0_IRQ, TIDC_M_CM1_IRQ, TIDC_M_WRAP_IRQ};
    logic [1:0] gr [5] = '{TIDC_GRP_CAPT, TIDC_GRP_CAPT, TIDC_GRP_COMP, TIDC_GRP_COMP, TIDC_GRP_WRAP};
    // ==========================================
    // Block and partner
    tidc_core dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .timer_flag_reg(timer_flag_reg),
        .capture0_eob_event(capture0_eob_event), .compare0_eob_event(compare0_eob_event),
        .dma_active_compare(dma_active_compare), .irq_request(irq_request),
        .irq_vector(irq_vector), .priority_level(priority_level),
        .capture0_dma_req(capture0_dma_req), .compare0_dma_req(compare0_dma_req),
        .dma_use_regfile(dma_use_regfile), .dma_use_dma_segment(dma_use_dma_segment),
        .dma_counter_addr(dma_counter_addr), .dma_address_addr(dma_address_addr),
        .capture_dma_source_sel(capture_dma_source_sel),
        .compare_dma_dest_sel(compare_dma_dest_sel));
    tidc_dma_partner partner (.clk_sys(clk_sys), .reset(reset), .block_len(block_len),
        .capture0_dma_req(capture0_dma_req), .compare0_dma_req(compare0_dma_req),
        .capture0_eob_event(capture0_eob_event), .compare0_eob_event(compare0_eob_event),
        .dma_active_compare(dma_active_compare));
    // ==========================================
    // Clock, 4 ns period
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // ==========================================
    // Bus and compare helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    // Data is valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // ==========================================
    // Scenarios
    task automatic t_reset;
        logic [7:0] ofs [6] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hff, 8'h10};
        logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h00, 8'hc7, 8'h00, 8'h00};
        logic [7:0] d;
        chk({4'h0, irq_request, priority_level}, 8'h07, "outputs after reset");
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], d);
            chk(d, exp[i], "reset value");
        end
        wr(8'h10, 8'hff); // Unmapped write must leave the map alone
        rd(TIDC_OFS_MASK, d);
        chk(d, 8'h00, "mask after stray write");
    endtask : t_reset
    // Each source against the global enable and its flag, with its mask set
    task automatic t_irq;
        logic [7:0] d;
        wr(TIDC_OFS_VECTOR, 8'hab);
        rd(TIDC_OFS_VECTOR, d);
        chk(d, 8'ha8, "vector base");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys) timer_flag_reg <= 8'(1 << fb[i]);
            wr(TIDC_OFS_MASK, 8'(1 << mb[i]));
            tick(3);
            chk(8'(irq_request), 8'h00, "irq with global off");
            wr(TIDC_OFS_MASK, 8'(8'h80 | (1 << mb[i])));
            tick(2);
            chk(8'(irq_request), 8'h01, "irq raised");
            tick(1);
            chk(irq_vector, {5'h15, gr[i], 1'b0}, "irq vector");
            @(posedge clk_sys) timer_flag_reg <= 8'h00;
            tick(2);
            chk(8'(irq_request), 8'h00, "irq without flag");
        end
        @(posedge clk_sys) timer_flag_reg <= 8'h81;
        wr(TIDC_OFS_MASK, 8'hb0);
        tick(2);
        chk(8'(irq_request), 8'h00, "and mode one capture");
        @(posedge clk_sys) timer_flag_reg <= 8'hc1;
        tick(2);
        chk(8'(irq_request), 8'h01, "and mode both captures");
        @(posedge clk_sys) timer_flag_reg <= 8'h00;
        wr(TIDC_OFS_MASK, 8'h00);
    endtask : t_irq
    // Arm one DMA channel, let the partner end the block
    task automatic t_dma(input int ch);
        logic [7:0] m, d;
        int i;
        m = (ch != 0) ? 8'h8c : 8'he0;
        @(posedge clk_sys) timer_flag_reg <= (ch != 0) ? 8'h20 : 8'h80;
        wr(TIDC_OFS_MASK, m);
        tick(2);
        chk(8'((ch != 0) ? compare0_dma_req : capture0_dma_req), 8'h01, "dma req");
        chk(8'(irq_request), 8'h00, "flag irq while armed");
        tick(1);
        chk(8'(dma_counter_addr[1]), 8'(ch), "channel select");
        for (i = 0; i < 40; i++) begin
            tick(1);
            if ((ch != 0) ? compare0_eob_event : capture0_eob_event) break;
        end
        if (i == 40) chk(8'h00, 8'h01, "end of block seen");
        tick(3);
        rd(TIDC_OFS_MASK, d);
        chk(d, m & ((ch != 0) ? 8'hf7 : 8'hbf), "arm cleared");
        chk(8'(capture0_dma_req | compare0_dma_req), 8'h00, "dma req off");
        chk(8'(irq_request), 8'h01, "end of block irq");
        chk(8'(irq_vector[2:1]), (ch != 0) ? 8'h03 : 8'h02, "group");
        @(posedge clk_sys) timer_flag_reg <= 8'h00;
        wr(TIDC_OFS_MASK, 8'h00);
    endtask : t_dma
    // Pointer fields, area and segment selection
    task automatic t_ptr;
        logic [7:0] d;
        wr(TIDC_OFS_CNT_PTR, 8'hfe);
        wr(TIDC_OFS_ADR_PTR, 8'h05);
        rd(TIDC_OFS_CNT_PTR, d);
        chk(d, 8'hfc, "counter pointer");
        rd(TIDC_OFS_ADR_PTR, d);
        chk(d, 8'h05, "address pointer");
        chk(dma_counter_addr, 8'hfc, "counter address");
        chk({6'h00, dma_use_regfile, dma_use_dma_segment}, 8'h01, "dma segment");
        wr(TIDC_OFS_ADR_PTR, 8'h04);
        tick(2);
        chk(8'(dma_use_dma_segment), 8'h00, "instruction segment");
        wr(TIDC_OFS_ADR_PTR, 8'h05);
        wr(TIDC_OFS_CNT_PTR, 8'hfd);
        tick(2);
        chk({6'h00, dma_use_regfile, dma_use_dma_segment}, 8'h02, "regfile area");
        chk(dma_address_addr, 8'h04, "table address");
    endtask : t_ptr
    // Swap mode, end-of-block flags, selects and priority
    task automatic t_ctrl;
        logic [7:0] d;
        wr(TIDC_OFS_CONTROL, 8'h3d);
        rd(TIDC_OFS_CONTROL, d);
        chk(d, 8'h3d, "control swap on");
        chk({3'h0, capture_dma_source_sel, compare_dma_dest_sel, priority_level}, 8'h1d,
            "selects and level");
        @(posedge clk_sys) block_len <= 4'h9; // Slow partner
        t_dma(1);
        rd(TIDC_OFS_CONTROL, d);
        chk(d, 8'h7d, "compare end flag");
        rd(TIDC_OFS_CNT_PTR, d);
        chk(d, 8'hf9, "counter swapped");
        rd(TIDC_OFS_ADR_PTR, d);
        chk(d, 8'h01, "address swapped");
        @(posedge clk_sys) block_len <= 4'h4;
        t_dma(0);
        rd(TIDC_OFS_CONTROL, d);
        chk(d, 8'hfd, "capture end flag");
        rd(TIDC_OFS_CNT_PTR, d);
        chk(d, 8'hf9, "counter kept");
        wr(TIDC_OFS_CONTROL, 8'h00);
        rd(TIDC_OFS_CONTROL, d);
        chk(d, 8'hc0, "flags forced");
        chk({3'h0, capture_dma_source_sel, compare_dma_dest_sel, priority_level}, 8'h00,
            "selects cleared");
    endtask : t_ctrl
    // ==========================================
    // Verdict, reached from the sequence or the watchdog
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #40000;
        n_errors++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        tick(1);
        t_reset();
        $display("reset test done");
        t_irq();
        $display("interrupt test done");
        t_dma(0);
        t_dma(1);
        $display("dma test done");
        t_ptr();
        $display("pointer test done");
        t_ctrl();
        $display("control test done");
        test_done();
    end
endmodule : tb_top
